// ### atc_defines.svh
// Register offsets, field positions, reset values and widths for the
// trigger and sampling control block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// ----------------------------------------------------------------
// Byte offsets of the registers (6-bit local address)
// ----------------------------------------------------------------
`define ATC_OFF_CHAN_EN 6'h00
`define ATC_OFF_DIV 6'h04
`define ATC_OFF_MODE 6'h08
`define ATC_OFF_LVL 6'h0C
`define ATC_OFF_SRC 6'h10
`define ATC_OFF_CNT 6'h14
`define ATC_OFF_STAT 6'h18
`define ATC_OFF_ARM 6'h1C
`define ATC_OFF_CLKSRC 6'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATC_SLOPE_BIT 3
`define ATC_SRC_EXT_BIT 2
`define ATC_ARM_BIT 0
`define ATC_CLRFIFO_BIT 0
`define ATC_TRIGGER_SEEN_CLEAR_BIT 1
`define ATC_ST_DONE_BIT 3
`define ATC_ST_SEEN_BIT 4
`define ATC_ST_ACQ_BIT 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ATC_RST_CHAN_EN 4'h0
`define ATC_RST_DIV 16'h0002
`define ATC_RST_MODE 3'h0
`define ATC_RST_LVL 8'h80
`define ATC_RST_SRC 3'h0
`define ATC_RST_CNT 16'h0000
`define ATC_RST_SLOPE 1'b0
`define ATC_RST_ARM 1'b0

`endif

// ### atc_pkg.sv
// Types shared by the trigger and sampling control block.
// Assumes nothing of its surroundings.
package atc_pkg;

	// ------------------------------------------------------------
	// Trigger modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ATC_MODE_SOFT = 3'h0,
		ATC_MODE_POST = 3'h1,
		ATC_MODE_PRE = 3'h2,
		ATC_MODE_DELAY = 3'h3,
		ATC_MODE_MIDDLE = 3'h4
	} atc_mode_t;

	// ------------------------------------------------------------
	// Acquisition sequencer states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ATC_ST_OFF = 4'h1,
		ATC_ST_WAIT = 4'h2,
		ATC_ST_ACQ = 4'h4,
		ATC_ST_STOP = 4'h8
	} atc_state_t;

endpackage : atc_pkg

// ### atc_clkdiv.sv
// Sampling clock divider: divides the source clock ticks by an even
// divisor. Assumes src_tick_i is a one-cycle pulse per source clock.
`timescale 1ns/1ps
`include "atc_defines.svh"

module atc_clkdiv (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic src_tick_i,
	input wire logic [15:0] divisor_i,
	output logic sclk_o,
	output logic rise_o
);

	// ------------------------------------------------------------
	// Half period
	// ------------------------------------------------------------
	logic [14:0] half; // Ticks per half period
	logic [14:0] cnt_r; // Tick counter
	logic wrap; // End of half period

	always_comb begin
		half = divisor_i[15:1];
		// Below the minimum acts as two
		if (half == 15'h0000) begin
			half = 15'h0001;
		end
	end

	assign wrap = (cnt_r >= (half - 15'h0001));

	// ------------------------------------------------------------
	// Counter and output level
	// ------------------------------------------------------------
	// divide source clock
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= 15'h0000;
			sclk_o <= 1'b0;
			rise_o <= 1'b0;
		end else begin
			rise_o <= src_tick_i && wrap && !sclk_o;
			if (src_tick_i) begin
				// Wrap also catches a shrunk divisor
				if (wrap) begin
					cnt_r <= 15'h0000;
					sclk_o <= ~sclk_o;
				end else begin
					cnt_r <= cnt_r + 15'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_rise_edge;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		rise_o |-> (sclk_o && !$past(sclk_o));
	endproperty
	a_rise_edge: assert property (p_rise_edge)
		else $error("rise pulse without clock edge");

	property p_no_stretch;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(src_tick_i && divisor_i[15:1] == 15'h0001 && cnt_r == 15'h0000)
		|=> (sclk_o != $past(sclk_o));
	endproperty
	a_no_stretch: assert property (p_no_stretch)
		else $error("divisor two did not toggle each tick");

endmodule : atc_clkdiv

// ### atc_top.sv
// Trigger and sampling control: register port, trigger detection,
// post-trigger counter and acquisition sequencer.
// Assumes a bus target front end delivering whole 32-bit accesses.
//
// Function
// - Whole 32-bit register accesses, bursts allowed
// - Enable bits 0..3 for channels 0..3
// - Sampling clock is source divided by divisor
// - Divisor at least two, low bit zero
// - Mode code selects one of five modes
// - Undefined mode code never acquires
// - Level is offset binary, 0x80 is zero
// - Condition combines level and slope registers
// - Source top bit picks external, else channel
// - Slope clear positive, set negative
// - External trigger uses edges, level ignored
// - Post-trigger counter is sixteen-bit down counter
// - Count register write preloads counter
// - Counter decrements per sample after trigger
// - Counter halts at zero, no wrap
// - Counter sets delay or middle sample count
// - Bits above fields ignored on write
// - Arm bit one arms, zero disables
// - Status bit 3 reports counter zero
// - Trigger seen sticky until software clears
`timescale 1ns/1ps
`include "atc_defines.svh"

module atc_top (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic [5:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic src_tick_i,
	input wire logic [7:0] chan0_code_i,
	input wire logic [7:0] chan1_code_i,
	input wire logic [7:0] chan2_code_i,
	input wire logic [7:0] chan3_code_i,
	input wire logic external_logic_trigger_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic [3:0] chan_enable_o,
	output logic sample_clk_o,
	output logic sample_strobe_o,
	output logic acquiring_o,
	output logic trigger_seen_flag_o,
	output logic after_count_done_o,
	output logic fifo_clear_o
);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic input0_on_r, input1_on_r, input2_on_r, input3_on_r;
	logic [15:0] divisor_value_r; // Sampling divisor
	logic [2:0] trigger_mode_code_r; // Trigger mode
	logic [7:0] trigger_threshold_code_r; // Offset binary level
	logic [2:0] trigger_origin_code_r; // Trigger source
	logic trigger_direction_r; // 0 rising, 1 falling
	logic acquisition_arm_bit_r; // Armed
	logic [15:0] cnt_r; // Post-trigger counter
	logic [15:0] cnt_nxt;
	logic trig_met_r; // Trigger met this run
	logic [7:0] prev_code_r; // Previous selected sample
	logic ext_prev_r; // Previous external level
	logic sclk_rise; // Sampling clock rising
	logic sclk_lvl;
	logic [15:0] wdata_lo; // Low half of write data
	atc_pkg::atc_state_t state_r, state_nxt;

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	logic wr_chen, wr_div, wr_mode, wr_lvl, wr_src, wr_cnt;
	logic wr_stat, wr_arm;
	logic trg_clear; // Clear request for seen flag

	always_comb begin
		wr_chen = 1'b0;
		wr_div = 1'b0;
		wr_mode = 1'b0;
		wr_lvl = 1'b0;
		wr_src = 1'b0;
		wr_cnt = 1'b0;
		wr_stat = 1'b0;
		wr_arm = 1'b0;
		if (!reg_wr_i) begin
			// No write this cycle
		end else if (reg_addr_i == `ATC_OFF_CHAN_EN) begin
			wr_chen = 1'b1;
		end else if (reg_addr_i == `ATC_OFF_DIV) begin
			wr_div = 1'b1;
		end else if (reg_addr_i == `ATC_OFF_MODE) begin
			wr_mode = 1'b1;
		end else if (reg_addr_i == `ATC_OFF_LVL) begin
			wr_lvl = 1'b1;
		end else if (reg_addr_i == `ATC_OFF_SRC) begin
			wr_src = 1'b1;
		end else if (reg_addr_i == `ATC_OFF_CNT) begin
			wr_cnt = 1'b1;
		end else if (reg_addr_i == `ATC_OFF_STAT) begin
			wr_stat = 1'b1;
		end else if (reg_addr_i == `ATC_OFF_ARM) begin
			wr_arm = 1'b1;
		end
		// Clock source and unmapped writes are dropped
	end

	assign wdata_lo = reg_wdata_i[15:0];
	assign trg_clear = wr_stat && reg_wdata_i[`ATC_TRIGGER_SEEN_CLEAR_BIT];

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// upper bits ignored
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{input3_on_r, input2_on_r, input1_on_r, input0_on_r}
				<= `ATC_RST_CHAN_EN;
			divisor_value_r <= `ATC_RST_DIV;
			trigger_mode_code_r <= `ATC_RST_MODE;
			trigger_threshold_code_r <= `ATC_RST_LVL;
			trigger_origin_code_r <= `ATC_RST_SRC;
			trigger_direction_r <= `ATC_RST_SLOPE;
			acquisition_arm_bit_r <= `ATC_RST_ARM;
		end else begin
			if (wr_chen) begin
				{input3_on_r, input2_on_r, input1_on_r, input0_on_r}
					<= reg_wdata_i[3:0];
			end
			if (wr_div) begin
				divisor_value_r <= wdata_lo;
			end
			if (wr_mode) begin
				trigger_mode_code_r <= reg_wdata_i[2:0];
			end
			if (wr_lvl) begin
				trigger_threshold_code_r <= reg_wdata_i[7:0];
			end
			if (wr_src) begin
				trigger_origin_code_r <= reg_wdata_i[2:0];
				trigger_direction_r <= reg_wdata_i[`ATC_SLOPE_BIT];
			end
			if (wr_arm) begin
				acquisition_arm_bit_r <= reg_wdata_i[`ATC_ARM_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Sampling clock divider
	// ------------------------------------------------------------
	atc_clkdiv u_clkdiv (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.src_tick_i(src_tick_i),
		.divisor_i(divisor_value_r),
		.sclk_o(sclk_lvl),
		.rise_o(sclk_rise)
	);

	// ------------------------------------------------------------
	// Trigger condition
	// ------------------------------------------------------------
	logic [7:0] sel_code; // Selected channel sample
	logic cond; // Raw trigger condition
	logic mode_legal;
	logic trig_window; // Trigger may be taken now
	logic trig_evt; // Trigger accepted

	always_comb begin
		case (trigger_origin_code_r[1:0])
			2'h0: sel_code = chan0_code_i;
			2'h1: sel_code = chan1_code_i;
			2'h2: sel_code = chan2_code_i;
			default: sel_code = chan3_code_i;
		endcase
	end

	always_comb begin
		cond = 1'b0;
		if (trigger_origin_code_r[`ATC_SRC_EXT_BIT]) begin
			if (trigger_direction_r) begin
				cond = ext_prev_r && !external_logic_trigger_i;
			end else begin
				cond = !ext_prev_r && external_logic_trigger_i;
			end
		end else if (sclk_rise) begin
			if (trigger_direction_r) begin
				cond = (prev_code_r >= trigger_threshold_code_r) &&
					(sel_code < trigger_threshold_code_r);
			end else begin
				cond = (prev_code_r < trigger_threshold_code_r) &&
					(sel_code >= trigger_threshold_code_r);
			end
		end
	end

	// History of the trigger inputs
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_code_r <= 8'h00;
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= external_logic_trigger_i;
			if (sclk_rise) begin
				prev_code_r <= sel_code;
			end
		end
	end

	assign mode_legal = (trigger_mode_code_r <= 3'h4);

	// Trigger counts only once per run and not in software mode
	always_comb begin
		trig_window = 1'b0;
		if (!trig_met_r) begin
			if (state_r == atc_pkg::ATC_ST_WAIT) begin
				trig_window = 1'b1;
			end else if (state_r == atc_pkg::ATC_ST_ACQ) begin
				trig_window =
					(trigger_mode_code_r == atc_pkg::ATC_MODE_PRE) ||
					(trigger_mode_code_r == atc_pkg::ATC_MODE_MIDDLE);
			end
		end
	end

	assign trig_evt = trig_window && cond;

	// ------------------------------------------------------------
	// Trigger flags
	// ------------------------------------------------------------
	// sticky, set wins
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			trigger_seen_flag_o <= 1'b0;
			trig_met_r <= 1'b0;
		end else begin
			if (trig_evt) begin
				trigger_seen_flag_o <= 1'b1;
			end else if (trg_clear) begin
				trigger_seen_flag_o <= 1'b0;
			end
			if (state_r == atc_pkg::ATC_ST_OFF) begin
				trig_met_r <= 1'b0;
			end else if (trig_evt) begin
				trig_met_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Post-trigger counter
	// ------------------------------------------------------------
	// sixteen-bit down count
	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_cnt) begin
			cnt_nxt = wdata_lo;
		end else if (trig_met_r && sclk_rise && cnt_r != 16'h0000) begin
			cnt_nxt = cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= `ATC_RST_CNT;
			after_count_done_o <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			after_count_done_o <= (cnt_nxt == 16'h0000);
		end
	end

	// ------------------------------------------------------------
	// Acquisition sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			atc_pkg::ATC_ST_OFF: begin
				if (acquisition_arm_bit_r && mode_legal) begin
					if (trigger_mode_code_r == atc_pkg::ATC_MODE_POST ||
						trigger_mode_code_r == atc_pkg::ATC_MODE_DELAY) begin
						state_nxt = atc_pkg::ATC_ST_WAIT;
					end else begin
						state_nxt = atc_pkg::ATC_ST_ACQ;
					end
				end
			end
			atc_pkg::ATC_ST_WAIT: begin
				if (trigger_mode_code_r == atc_pkg::ATC_MODE_POST) begin
					if (trig_evt) begin
						state_nxt = atc_pkg::ATC_ST_ACQ;
					end
				end else if (trig_met_r && cnt_r == 16'h0000) begin
					state_nxt = atc_pkg::ATC_ST_ACQ;
				end
			end
			atc_pkg::ATC_ST_ACQ: begin
				if (trigger_mode_code_r == atc_pkg::ATC_MODE_PRE) begin
					if (trig_evt) begin
						state_nxt = atc_pkg::ATC_ST_STOP;
					end
				end else if (trigger_mode_code_r ==
					atc_pkg::ATC_MODE_MIDDLE) begin
					if (trig_met_r && cnt_r == 16'h0000) begin
						state_nxt = atc_pkg::ATC_ST_STOP;
					end
				end
			end
			atc_pkg::ATC_ST_STOP: begin
				// Held until disarmed or the mode code becomes undefined
			end
			default: state_nxt = atc_pkg::ATC_ST_OFF;
		endcase
		if (!acquisition_arm_bit_r || !mode_legal) begin
			state_nxt = atc_pkg::ATC_ST_OFF;
		end
	end

	// State register and sampling outputs
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= atc_pkg::ATC_ST_OFF;
			acquiring_o <= 1'b0;
			sample_strobe_o <= 1'b0;
			sample_clk_o <= 1'b0;
			chan_enable_o <= `ATC_RST_CHAN_EN;
		end else begin
			state_r <= state_nxt;
			acquiring_o <= (state_nxt == atc_pkg::ATC_ST_ACQ);
			sample_strobe_o <= sclk_rise &&
				(state_r == atc_pkg::ATC_ST_ACQ);
			sample_clk_o <= sclk_lvl;
			chan_enable_o <= {input3_on_r, input2_on_r,
				input1_on_r, input0_on_r};
		end
	end

	// ------------------------------------------------------------
	// Read port and control pulses
	// ------------------------------------------------------------
	// full word reads
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 32'h00000000;
			reg_rvalid_o <= 1'b0;
			fifo_clear_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			fifo_clear_o <= wr_stat && reg_wdata_i[`ATC_CLRFIFO_BIT];
			reg_rdata_o <= 32'h00000000;
			// Only status is readable; others read zero
			if (reg_rd_i && reg_addr_i == `ATC_OFF_STAT) begin
				reg_rdata_o[`ATC_ST_DONE_BIT] <= after_count_done_o;
				reg_rdata_o[`ATC_ST_SEEN_BIT] <= trigger_seen_flag_o;
				reg_rdata_o[`ATC_ST_ACQ_BIT] <= acquiring_o;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_preload;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		wr_cnt |=> (cnt_r == $past(wdata_lo));
	endproperty
	a_preload: assert property (p_preload)
		else $error("counter not preloaded");

	property p_halt;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(cnt_r == 16'h0000 && !wr_cnt) |=> (cnt_r == 16'h0000);
	endproperty
	a_halt: assert property (p_halt)
		else $error("counter left zero without preload");

	property p_dec;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(trig_met_r && sclk_rise && cnt_r != 16'h0000 && !wr_cnt)
		|=> (cnt_r == $past(cnt_r) - 16'h0001);
	endproperty
	a_dec: assert property (p_dec)
		else $error("counter did not decrement");

	property p_illegal;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		!mode_legal |=> !acquiring_o;
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("acquiring in undefined mode");

	property p_seen_hold;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(trigger_seen_flag_o && !trg_clear) |=> trigger_seen_flag_o;
	endproperty
	a_seen_hold: assert property (p_seen_hold)
		else $error("trigger flag dropped without clear");

	property p_seen_set;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		trig_evt |=> trigger_seen_flag_o;
	endproperty
	a_seen_set: assert property (p_seen_set)
		else $error("trigger event lost");

	property p_soft_start;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state_r == atc_pkg::ATC_ST_OFF && acquisition_arm_bit_r &&
			trigger_mode_code_r == atc_pkg::ATC_MODE_SOFT)
		|=> acquiring_o;
	endproperty
	a_soft_start: assert property (p_soft_start)
		else $error("software mode did not start");

	property p_chen;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		wr_chen |=> ##1 (chan_enable_o == $past(reg_wdata_i[3:0], 2));
	endproperty
	a_chen: assert property (p_chen)
		else $error("channel enables wrong");

	property p_done;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		after_count_done_o == (cnt_r == 16'h0000);
	endproperty
	a_done: assert property (p_done)
		else $error("zero flag disagrees with counter");

	property p_ext_edge;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(trig_evt && trigger_origin_code_r[`ATC_SRC_EXT_BIT]) |->
		(external_logic_trigger_i != ext_prev_r) &&
		(external_logic_trigger_i == !trigger_direction_r);
	endproperty
	a_ext_edge: assert property (p_ext_edge)
		else $error("external trigger on wrong edge");

endmodule : atc_top

// ### atc_host_model.sv
// Host model: a bus master on the local register port of the block.
// Assumes its tasks are entered one time unit after a rising edge.
`timescale 1ns/1ps

module atc_host_model (
	input wire logic sys_clk_i,
	input wire logic [31:0] rdata_i,
	input wire logic rvalid_i,
	output logic [5:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [31:0] wdata_o
);
	// ----------------------------------------------------------
	// Bus lines
	// ----------------------------------------------------------
	// Idle bus at time zero
	initial begin
		addr_o = 6'h3F;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 32'h0;
	end

	// Released lines never keep the last value
	task automatic idle();
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask : idle

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge sys_clk_i);
		#1;
		wr_o = 1'b0;
		idle();
		@(posedge sys_clk_i);
		#1;
	endtask : wr

	// whole word reads, answer one cycle on
	task automatic rd(input logic [5:0] a, output logic [31:0] d,
		output logic v);
		addr_o = a;
		rd_o = 1'b1;
		@(posedge sys_clk_i);
		#1;
		rd_o = 1'b0;
		v = rvalid_i;
		d = rdata_i;
		idle();
		@(posedge sys_clk_i);
		#1;
	endtask : rd
endmodule : atc_host_model

// ### atc_tb.sv
// Bench for the trigger and sampling control block.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`include "atc_defines.svh"

module tb;
	// ----------------------------------------------------------
	// Signals
	// ----------------------------------------------------------
	logic sys_clk_i, arst_n_i, wr, rd, rv, ext, tick;
	logic [5:0] addr;
	logic [31:0] wd, rdat, d;
	logic [7:0] c0, c1, c2, c3;
	logic [3:0] en;
	logic sclk, stb, acq, seen, done, v, fclr;
	int bad_count = 0;
	int cmp_count = 0;
	int n, g, nstb, nclr;

	atc_host_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdat),
		.rvalid_i(rv), .addr_o(addr), .wr_o(wr), .rd_o(rd),
		.wdata_o(wd));

	atc_top uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wd), .src_tick_i(tick), .chan0_code_i(c0),
		.chan1_code_i(c1), .chan2_code_i(c2), .chan3_code_i(c3),
		.external_logic_trigger_i(ext), .reg_rdata_o(rdat),
		.reg_rvalid_o(rv), .chan_enable_o(en), .sample_clk_o(sclk),
		.sample_strobe_o(stb), .acquiring_o(acq),
		.trigger_seen_flag_o(seen), .after_count_done_o(done),
		.fifo_clear_o(fclr));

	// Clock, 40 ns period
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	// Strobe and buffer clear pulse counters
	always @(posedge sys_clk_i) begin
		if (stb === 1'b1) nstb <= nstb + 1;
		if (fclr === 1'b1) nclr <= nclr + 1;
	end

	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk_i);
		#1;
	endtask : cyc

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
			bad_count++;
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// Cycles between two strobes
	task automatic gap(output int k);
		n = 0;
		while (stb !== 1'b1 && n < 100) begin cyc(1); n++; end
		k = 0;
		do begin cyc(1); k++; end while (stb !== 1'b1 && k < 100);
	endtask : gap

	// One triggered run on the external input
	task automatic run(input logic [2:0] m, input logic [3:0] s,
		input logic ea, input logic eb);
		ext = s[3];
		host.wr(`ATC_OFF_ARM, 32'h0);
		host.wr(`ATC_OFF_MODE, {29'h0, m});
		host.wr(`ATC_OFF_SRC, {28'h0, s});
		host.wr(`ATC_OFF_CNT, 32'h3);
		host.wr(`ATC_OFF_STAT, 32'h2);
		chk("preload", 0, done);
		host.wr(`ATC_OFF_ARM, 32'h1);
		cyc(2);
		chk("armed acq", ea, acq);
		chk("no early trig", 0, seen);
		ext = ~s[3];
		n = 0;
		while (seen !== 1'b1 && n < 20) begin cyc(1); n++; end
		chk("edge trig", 1, seen);
		n = 0;
		while (done !== 1'b1 && n < 100) begin cyc(1); n++; end
		chk("count span", 1, n >= 6 && n <= 16);
		cyc(3);
		chk("final acq", eb, acq);
		cyc(12);
		chk("halt at zero", 1, done);
	endtask : run

	// ----------------------------------------------------------
	// Tests
	// ----------------------------------------------------------
	initial begin
		arst_n_i = 1'b0;
		ext = 1'b0;
		tick = 1'b1;
		c0 = 8'h40;
		c1 = 8'h40;
		c2 = 8'h40;
		c3 = 8'h40;
		nstb = 0;
		nclr = 0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		arst_n_i = 1'b1;
		chk("reset acq", 0, acq);
		host.rd(`ATC_OFF_STAT, d, v);
		chk("status", 32'h8, d);
		chk("rvalid", 1, v);
		host.rd(`ATC_OFF_CHAN_EN, d, v);
		chk("wo read", 0, d);
		for (int i = 0; i < 4; i++) begin
			n = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 3 : 15;
			host.wr(`ATC_OFF_CHAN_EN, {28'hABCDEF5, n[3:0]});
			cyc(1);
			chk("enables", n, en);
		end
		host.wr(`ATC_OFF_CNT, 32'hFFFF0003);
		chk("preload", 0, done);
		host.wr(`ATC_OFF_CNT, 32'h00010000);
		chk("upper ignored", 1, done);
		host.wr(`ATC_OFF_DIV, 32'h4);
		host.wr(`ATC_OFF_MODE, 32'h0);
		host.wr(`ATC_OFF_ARM, 32'h1);
		chk("soft acq", 1, acq);
		for (int k = 4; k <= 6; k++) begin
			host.wr(`ATC_OFF_DIV, k);
			gap(g);
			gap(g);
			chk("sample period", k & 6, g);
			chk("sample clock", 1, sclk);
		end
		host.wr(`ATC_OFF_ARM, 32'h0);
		chk("disarm", 0, acq);
		for (int m = 5; m <= 7; m++) begin
			host.wr(`ATC_OFF_MODE, m);
			host.wr(`ATC_OFF_ARM, 32'h1);
			g = nstb;
			cyc(10);
			chk("bad mode", 0, {acq, 8'(nstb - g)});
			host.wr(`ATC_OFF_ARM, 32'h0);
		end
		host.wr(`ATC_OFF_DIV, 32'h4);
		run(3'h1, 4'h4, 1'b0, 1'b1);
		run(3'h2, 4'h4, 1'b1, 1'b0);
		run(3'h3, 4'hC, 1'b0, 1'b1);
		run(3'h4, 4'hC, 1'b1, 1'b0);
		host.wr(`ATC_OFF_ARM, 32'h0);
		host.wr(`ATC_OFF_MODE, 32'h1);
		host.wr(`ATC_OFF_SRC, 32'h1);
		host.wr(`ATC_OFF_LVL, 32'hFFFFFF80);
		host.wr(`ATC_OFF_CNT, 32'h0);
		host.wr(`ATC_OFF_STAT, 32'h2);
		host.wr(`ATC_OFF_ARM, 32'h1);
		cyc(20);
		c0 = 8'hFF;
		c2 = 8'hFF;
		c3 = 8'hFF;
		cyc(20);
		chk("other chan", 0, seen);
		c1 = 8'h80;
		cyc(20);
		chk("level cross", 1, seen);
		host.rd(`ATC_OFF_STAT, d, v);
		chk("status trig", 32'h38, d);
		host.wr(`ATC_OFF_STAT, 32'h2);
		chk("seen clear", 0, seen);
		// Channel 3, negative slope
		host.wr(`ATC_OFF_ARM, 32'h0);
		host.wr(`ATC_OFF_SRC, 32'hB);
		host.wr(`ATC_OFF_ARM, 32'h1);
		cyc(20);
		chk("no fall yet", 0, seen);
		c3 = 8'h10;
		cyc(20);
		chk("level fall", 1, seen);
		host.wr(`ATC_OFF_STAT, 32'h1);
		chk("seen kept", 1, seen);
		chk("fifo clear", 1, nclr);
		give_verdict();
	end

	// Watchdog
	initial begin
		#(40 * 20000);
		bad_count++;
		give_verdict();
	end
endmodule : tb
